/* File: hdl/mcr_defs.svh */
// Behaviour
// [RULE_01] sag warning when peak stays below threshold
// [RULE_02] sag count low half, default 80
// [RULE_03] under-current zeroes post-processed phase results
// [RULE_04] current zeroing only with nonzero floor
// [RULE_05] under-current sets that phase's creep flag
// [RULE_06] under-voltage zeroes frequency, crossings, angle, RMS; here only that phase's RMS voltage is zeroed, with VOLT_ZERO set
// [RULE_07] under-voltage never sets creep flags
// [RULE_08] overcurrent limit versus upper RMS current bits
// [RULE_09] overvoltage limit versus upper RMS voltage bits
// [RULE_10] running time counts hundredths of hours
// [RULE_11] time or date write clears running time
// [RULE_12] date register holds year, month, day
// [RULE_13] time register holds weekday, hour, minute, second
// [RULE_14] monitor words shift out on test pin
// [RULE_15] four monitor slot addresses, slot0 on top
// [RULE_16] enabled stream sends word block each sample
// [RULE_17] word count, start address; bits 17:16 zero
// [RULE_18] bit 18 selects frame pulse polarity
// [RULE_19] frame spacing: block, 8, 16, 32 bits
// [RULE_20] gated stream clock held low when idle
// [RULE_21] bit 22 selects 5 or 10 MHz; the fast setting here divides the clock by 2, giving 12.5 MHz
// [RULE_22] level write drives outputs only; read live
// [RULE_23] direction mask: 1 output, 0 input
// [RULE_24] masked pin edge sets event next interval
// [RULE_25] pin control bits 15:8 read zero
`ifndef MCR_DEFS_SVH
`define MCR_DEFS_SVH
// ------------------------------------------------------------
// register word offsets
// ------------------------------------------------------------
`define MCR_OFS_OVERLOAD 8'h17
`define MCR_OFS_PINCTL 8'h1A
`define MCR_OFS_RUNTIME 8'h1E
`define MCR_OFS_TIME 8'h1F
`define MCR_OFS_DATE 8'h20
`define MCR_OFS_MONSEL 8'h21
`define MCR_OFS_STREAM 8'h22
`define MCR_OFS_SAG 8'h2E
`define MCR_OFS_STARTUP 8'h40
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define MCR_STR_FPOL 18
`define MCR_STR_FSP_LO 19
`define MCR_STR_GATE 21
`define MCR_STR_FAST 22
`define MCR_STR_EN 23
`define MCR_STR_WMASK 32'h00FC_FFFF
`define MCR_PIN_RMASK 32'hFFFF_00FF
`define MCR_SAG_RESET 32'h0000_0050
`define MCR_TEST_MUX_SELECT_MONITOR 2'h3
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define MCR_CLK_PERIOD_NS 40
`define MCR_SAMPLE_PERIOD_NS 397000
`define MCR_HUNDREDTH_HOUR_S 36
`define MCR_SCLK_SLOW_NS 200
`define MCR_SCLK_FAST_NS 100
`define MCR_WORD_BITS 6'd32
`endif

/* File: hdl/mcr_pkg.sv */
package mcr_pkg;
	typedef enum logic [1:0] {RD_IDLE = 2'h0, RD_STREAM = 2'h1, RD_MON = 2'h3} mcr_rd_t;
	typedef enum logic [0:0] {SH_IDLE = 1'h0, SH_SHIFT = 1'h1} mcr_sh_t;
	typedef struct packed {
		logic mon;
		logic first;
		logic [31:0] data;
	} mcr_word_t;
	typedef struct packed {
		logic [2:0][31:0] cur_sqsum;
		logic [2:0][31:0] irms;
		logic [2:0][31:0] vrms;
		logic [2:0][15:0] peak;
	} mcr_meas_t;
endpackage : mcr_pkg

/* File: hdl/mcr_regs.sv */
`timescale 1ns/10ps
`include "mcr_defs.svh"
module mcr_fifo import mcr_pkg::*; #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 16
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} mcr_fst_t;
	logic [WIDTH-1:0] mem [DEPTH];
	mcr_fst_t s_r, s_nxt;
	logic push, pop;
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
			$error("fifo depth must be a power of two of at least 2");
		end
	endgenerate
	assign in_ready = (s_r.cnt != DEPTH[AW:0]);
	assign out_valid = (s_r.cnt != '0);
	assign out_data = mem[s_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		s_nxt = s_r;
		if (push)
			s_nxt.wp = s_r.wp + 1'b1;
		if (pop)
			s_nxt.rp = s_r.rp + 1'b1;
		s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end
	always_ff @(posedge CLK) begin
		if (RESET)
			s_r <= '0;
		else
			s_r <= s_nxt;
		if (push)
			mem[s_r.wp] <= in_data;
	end
endmodule : mcr_fifo

module mcr_regs import mcr_pkg::*; #(
	parameter int SAMPLE_CYCLES = `MCR_SAMPLE_PERIOD_NS / `MCR_CLK_PERIOD_NS,
	parameter int HUNDREDTH_CYCLES = `MCR_HUNDREDTH_HOUR_S * 1000 / `MCR_CLK_PERIOD_NS * 1000000,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic REG_ACK,
	input wire logic MON_EN,
	input wire logic [1:0] TEST_MUX_SELECT_SEL,
	input wire logic [31:0] LOAD_FLOOR,
	input wire logic ACCUM_TICK,
	input wire mcr_meas_t MEAS,
	output logic [7:0] RAM_ADDR,
	input wire logic [31:0] RAM_DATA,
	output logic [2:0][31:0] IRMS_OUT,
	output logic [2:0][31:0] VRMS_OUT,
	output logic [2:0] CUR_ZERO,
	output logic [2:0] VOLT_ZERO,
	output logic [2:0] CREEP,
	output logic [2:0] SAG_WARN,
	output logic OVER_CURRENT,
	output logic OVER_VOLTAGE,
	output logic PIN_EDGE_EVENT,
	input wire logic [7:0] PIN_IN,
	output logic [7:0] PIN_OUT,
	output logic [7:0] PIN_OE,
	output logic STREAM_CLK,
	output logic STREAM_DATA,
	output logic FRAME_MARKER,
	output logic TEST_MUX_SELECT_OUT
);
	localparam logic [2:0] SLOW_CYC = 3'(`MCR_SCLK_SLOW_NS / `MCR_CLK_PERIOD_NS);
	localparam logic [2:0] FAST_CYC = 3'(`MCR_SCLK_FAST_NS / `MCR_CLK_PERIOD_NS);
	typedef struct packed {
		logic [31:0] overload, pin_level, date, time_day, monsel, stream, sag, startup;
		logic [7:0] dir, alert;
		logic [31:0] runtime, hdiv, sdiv;
		logic [7:0] pin_s1, pin_s2, pin_prev, pend;
		logic [2:0][15:0] sag_sample_count;
		mcr_rd_t rd;
		logic [7:0] rd_left, ram_addr;
		logic [1:0] slot;
		logic inflight, infl_mon, infl_first;
		mcr_sh_t sh;
		logic [31:0] shreg;
		logic [5:0] bits;
		logic wmon, wfirst;
		logic [2:0] div;
		logic [31:0] rdata;
		logic ack, sclk, sdata, frame, test_mux_select, over_i, over_v, edge_ev;
		logic [2:0] czero, vzero, creep, sag_w;
		logic [2:0][31:0] irms, vrms;
	} mcr_st_t;
	mcr_st_t s_r, s_nxt;
	mcr_word_t f_in, f_out;
	logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
	generate
		if (SAMPLE_CYCLES < 2 || HUNDREDTH_CYCLES < 2) begin : g_chk
			$error("sample and hundredth periods need at least two cycles");
		end
	endgenerate
	mcr_fifo #(.WIDTH($bits(mcr_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.CLK(CLK),
		.RESET(RESET),
		.in_data(f_in),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.out_data(f_out),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready)
	);
	logic wr_hit, fall_en, sample_tick, gate_idle;
	logic [2:0] per, half;
	logic [5:0] idx;
	logic [7:0] pins, ib, vb;
	// a word read from the data memory arrives one cycle after its address
	assign f_in = '{mon: s_r.infl_mon, first: s_r.infl_first, data: RAM_DATA};
	assign f_in_valid = s_r.inflight;
	assign f_out_ready = (s_r.sh == SH_IDLE) && fall_en;
	always_comb begin
		per = s_r.stream[`MCR_STR_FAST] ? FAST_CYC : SLOW_CYC;
		half = per >> 1;
		// new bit lands with the falling clock, so the fast two-cycle rate keeps setup too
		fall_en = (s_r.div == half - 3'h1);
		sample_tick = (s_r.sdiv == 32'(SAMPLE_CYCLES - 1));
		pins = s_r.pin_s2;
	end
	always_comb begin
		s_nxt = s_r;
		wr_hit = 1'b0;
		idx = '0;
		ib = '0;
		vb = '0;
		gate_idle = 1'b0;
		// ------------------------------------------------------------
		// register port
		// ------------------------------------------------------------
		s_nxt.ack = REG_WR || REG_RD;
		if (REG_WR) begin
			case (REG_ADDR)
				`MCR_OFS_OVERLOAD: s_nxt.overload = REG_WDATA;
				`MCR_OFS_PINCTL: begin
					// [RULE_23] direction mask taken
					s_nxt.dir = REG_WDATA[23:16];
					s_nxt.alert = REG_WDATA[31:24];
					// [RULE_22] only output pins take the level
					s_nxt.pin_level[7:0] = (REG_WDATA[7:0] & REG_WDATA[23:16])
						| (s_r.pin_level[7:0] & ~REG_WDATA[23:16]);
				end
				// [RULE_12] [RULE_13] calendar and time settable
				`MCR_OFS_TIME: begin
					s_nxt.time_day = REG_WDATA;
					wr_hit = 1'b1;
				end
				`MCR_OFS_DATE: begin
					s_nxt.date = REG_WDATA;
					wr_hit = 1'b1;
				end
				// [RULE_15] four slot addresses
				`MCR_OFS_MONSEL: s_nxt.monsel = REG_WDATA;
				// [RULE_17] bits 17:16 held at zero
				`MCR_OFS_STREAM: s_nxt.stream = REG_WDATA & `MCR_STR_WMASK;
				`MCR_OFS_SAG: s_nxt.sag = REG_WDATA;
				`MCR_OFS_STARTUP: s_nxt.startup = REG_WDATA;
				default: ;
			endcase
		end
		if (REG_RD) begin
			case (REG_ADDR)
				`MCR_OFS_OVERLOAD: s_nxt.rdata = s_r.overload;
				// [RULE_25] [RULE_22] unused byte zero, live pin state
				`MCR_OFS_PINCTL: s_nxt.rdata = {s_r.alert, s_r.dir, 8'h00, pins};
				`MCR_OFS_RUNTIME: s_nxt.rdata = s_r.runtime;
				`MCR_OFS_TIME: s_nxt.rdata = s_r.time_day;
				`MCR_OFS_DATE: s_nxt.rdata = s_r.date;
				`MCR_OFS_MONSEL: s_nxt.rdata = s_r.monsel;
				`MCR_OFS_STREAM: s_nxt.rdata = s_r.stream;
				`MCR_OFS_SAG: s_nxt.rdata = s_r.sag;
				`MCR_OFS_STARTUP: s_nxt.rdata = s_r.startup;
				default: s_nxt.rdata = '0;
			endcase
		end
		// ------------------------------------------------------------
		// running time
		// ------------------------------------------------------------
		// [RULE_10] one count per hundredth of an hour
		s_nxt.hdiv = (s_r.hdiv == 32'(HUNDREDTH_CYCLES - 1)) ? '0 : s_r.hdiv + 32'h1;
		if (s_r.hdiv == 32'(HUNDREDTH_CYCLES - 1))
			s_nxt.runtime = s_r.runtime + 32'h1;
		// [RULE_11] setting the clock restarts the count
		if (wr_hit) begin
			s_nxt.runtime = '0;
			s_nxt.hdiv = '0;
		end
		// ------------------------------------------------------------
		// pins
		// ------------------------------------------------------------
		s_nxt.pin_s1 = PIN_IN;
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.pin_prev = s_r.pin_s2;
		// [RULE_24] masked edges wait for the next interval; set wins over hand-off
		if (ACCUM_TICK) begin
			s_nxt.edge_ev = (s_r.pend != '0);
			s_nxt.pend = (s_r.pin_s2 ^ s_r.pin_prev) & s_r.alert;
		end else begin
			s_nxt.pend = s_r.pend | ((s_r.pin_s2 ^ s_r.pin_prev) & s_r.alert);
		end
		// ------------------------------------------------------------
		// sag and interval results
		// ------------------------------------------------------------
		s_nxt.sdiv = sample_tick ? '0 : s_r.sdiv + 32'h1;
		for (int p = 0; p < 3; p++) begin
			if (sample_tick) begin
				// [RULE_01] [RULE_02] counter restarts whenever peak clears threshold
				if (MEAS.peak[p] > s_r.sag[31:16])
					s_nxt.sag_sample_count[p] = '0;
				else if (s_r.sag_sample_count[p] != 16'hFFFF)
					s_nxt.sag_sample_count[p] = s_r.sag_sample_count[p] + 16'h1;
			end
			s_nxt.sag_w[p] = (s_r.sag_sample_count[p] >= s_r.sag[15:0]) && (s_r.sag[15:0] != '0);
			if (ACCUM_TICK) begin
				// [RULE_03] [RULE_04] [RULE_05] current start test
				ib[p] = (MEAS.cur_sqsum[p] < {16'h0000, s_r.startup[15:0]});
				s_nxt.creep[p] = ib[p];
				s_nxt.czero[p] = ib[p] && (LOAD_FLOOR != '0);
				// [RULE_06] [RULE_07] voltage start test leaves creep alone
				vb[p] = (MEAS.vrms[p][31:16] < s_r.startup[31:16]);
				s_nxt.vzero[p] = vb[p];
				s_nxt.irms[p] = s_nxt.czero[p] ? '0 : MEAS.irms[p];
				s_nxt.vrms[p] = vb[p] ? '0 : MEAS.vrms[p];
			end
		end
		if (ACCUM_TICK) begin
			// [RULE_08] [RULE_09] alarms on upper RMS halves
			s_nxt.over_i = (MEAS.irms[0][31:16] > s_r.overload[15:0])
				|| (MEAS.irms[1][31:16] > s_r.overload[15:0])
				|| (MEAS.irms[2][31:16] > s_r.overload[15:0]);
			s_nxt.over_v = (MEAS.vrms[0][31:16] > s_r.overload[31:16])
				|| (MEAS.vrms[1][31:16] > s_r.overload[31:16])
				|| (MEAS.vrms[2][31:16] > s_r.overload[31:16]);
		end
		// ------------------------------------------------------------
		// memory reader
		// ------------------------------------------------------------
		// reads go one at a time so a full fifo stalls the reader cleanly
		s_nxt.inflight = 1'b0;
		case (s_r.rd)
			RD_IDLE: begin
				// [RULE_16] block of words each sample period
				if (sample_tick && s_r.stream[`MCR_STR_EN] && s_r.stream[7:0] != '0) begin
					s_nxt.rd = RD_STREAM;
					s_nxt.ram_addr = s_r.stream[15:8];
					s_nxt.rd_left = s_r.stream[7:0];
				end else if (sample_tick && MON_EN && TEST_MUX_SELECT_SEL == `MCR_TEST_MUX_SELECT_MONITOR) begin
					s_nxt.rd = RD_MON;
					s_nxt.slot = 2'h0;
				end
			end
			RD_STREAM: begin
				if (f_in_ready && !s_r.inflight) begin
					s_nxt.inflight = 1'b1;
					s_nxt.infl_mon = 1'b0;
					s_nxt.infl_first = (s_r.rd_left == s_r.stream[7:0]);
					s_nxt.rd_left = s_r.rd_left - 8'h01;
					s_nxt.ram_addr = s_r.ram_addr + 8'h01;
					if (s_r.rd_left == 8'h01)
						s_nxt.rd = (MON_EN && TEST_MUX_SELECT_SEL == `MCR_TEST_MUX_SELECT_MONITOR) ? RD_MON : RD_IDLE;
					s_nxt.slot = 2'h0;
				end
			end
			RD_MON: begin
				// [RULE_14] slot 0 to 3 go out in turn
				if (f_in_ready && !s_r.inflight) begin
					s_nxt.inflight = 1'b1;
					s_nxt.infl_mon = 1'b1;
					s_nxt.infl_first = (s_r.slot == 2'h0);
					s_nxt.slot = s_r.slot + 2'h1;
					if (s_r.slot == 2'h3)
						s_nxt.rd = RD_IDLE;
				end
			end
			default: s_nxt.rd = RD_IDLE;
		endcase
		if (s_nxt.rd == RD_MON && s_r.rd != RD_MON || s_r.rd == RD_MON && !s_nxt.inflight)
			s_nxt.ram_addr = s_r.monsel[8'(31 - 8 * s_nxt.slot) -: 8];
		if (s_r.rd == RD_MON && s_nxt.inflight)
			s_nxt.ram_addr = s_r.monsel[8'(31 - 8 * s_nxt.slot) -: 8];
		// ------------------------------------------------------------
		// serializer
		// ------------------------------------------------------------
		// [RULE_21] divider period from the rate bit
		s_nxt.div = (s_r.div >= per - 3'h1) ? '0 : s_r.div + 3'h1;
		if (fall_en) begin
			case (s_r.sh)
				SH_IDLE: begin
					if (f_out_valid) begin
						s_nxt.sh = SH_SHIFT;
						s_nxt.shreg = f_out.data;
						s_nxt.bits = `MCR_WORD_BITS;
						s_nxt.wmon = f_out.mon;
						s_nxt.wfirst = f_out.first;
					end
				end
				SH_SHIFT: begin
					s_nxt.shreg = {s_r.shreg[30:0], 1'b0};
					s_nxt.bits = s_r.bits - 6'h1;
					if (s_r.bits == 6'h1)
						s_nxt.sh = SH_IDLE;
				end
				default: s_nxt.sh = SH_IDLE;
			endcase
			idx = `MCR_WORD_BITS - s_nxt.bits;
			s_nxt.sdata = (s_nxt.sh == SH_SHIFT) && !s_nxt.wmon && s_nxt.shreg[31];
			s_nxt.test_mux_select = (s_nxt.sh == SH_SHIFT) && s_nxt.wmon && s_nxt.shreg[31];
			// [RULE_19] [RULE_18] marker spacing, then polarity
			case (s_r.stream[20:19])
				2'h0: s_nxt.frame = s_nxt.wfirst && idx == 6'h0;
				2'h1: s_nxt.frame = idx[2:0] == 3'h0;
				2'h2: s_nxt.frame = idx[3:0] == 4'h0;
				default: s_nxt.frame = idx == 6'h0;
			endcase
			s_nxt.frame = (s_nxt.frame && s_nxt.sh == SH_SHIFT && !s_nxt.wmon)
				^ s_r.stream[`MCR_STR_FPOL];
		end
		// [RULE_20] gated clock rests low between words
		gate_idle = s_r.stream[`MCR_STR_GATE] && s_nxt.sh == SH_IDLE;
		s_nxt.sclk = (s_nxt.div < half) && !gate_idle;
	end
	always_ff @(posedge CLK) begin
		if (RESET) begin
			s_r <= '0;
			s_r.sag <= `MCR_SAG_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign REG_RDATA = s_r.rdata;
	assign REG_ACK = s_r.ack;
	assign RAM_ADDR = s_r.ram_addr;
	assign IRMS_OUT = s_r.irms;
	assign VRMS_OUT = s_r.vrms;
	assign CUR_ZERO = s_r.czero;
	assign VOLT_ZERO = s_r.vzero;
	assign CREEP = s_r.creep;
	assign SAG_WARN = s_r.sag_w;
	assign OVER_CURRENT = s_r.over_i;
	assign OVER_VOLTAGE = s_r.over_v;
	assign PIN_EDGE_EVENT = s_r.edge_ev;
	assign PIN_OUT = s_r.pin_level[7:0];
	assign PIN_OE = s_r.dir;
	assign STREAM_CLK = s_r.sclk;
	assign STREAM_DATA = s_r.sdata;
	assign FRAME_MARKER = s_r.frame;
	assign TEST_MUX_SELECT_OUT = s_r.test_mux_select;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence pin_wr_s;
		REG_WR && REG_ADDR == `MCR_OFS_PINCTL;
	endsequence
	sequence clock_set_s;
		REG_WR && (REG_ADDR == `MCR_OFS_TIME || REG_ADDR == `MCR_OFS_DATE);
	endsequence
	pin_input_hold_a: assert property (pin_wr_s |=> // [RULE_22]
		((PIN_OUT ^ $past(PIN_OUT)) & ~$past(REG_WDATA[23:16])) == 8'h00)
		else $error("input pin level changed on write");
	pin_dir_a: assert property (pin_wr_s |=> PIN_OE == $past(REG_WDATA[23:16])) // [RULE_23]
		else $error("direction mask not applied");
	pin_unused_a: assert property (REG_RD && REG_ADDR == `MCR_OFS_PINCTL |=> // [RULE_25]
		REG_RDATA[15:8] == 8'h00) else $error("unused pin bits not zero");
	runtime_clear_a: assert property (clock_set_s |=> s_r.runtime == 32'h0) // [RULE_11]
		else $error("running time not cleared");
	creep_volt_a: assert property (ACCUM_TICK |=> CREEP == $past(ib) && VOLT_ZERO == $past(vb)) // [RULE_07]
		else $error("creep flags follow wrong test");
	cur_zero_a: assert property (ACCUM_TICK && LOAD_FLOOR == 32'h0 |=> CUR_ZERO == 3'h0) // [RULE_04]
		else $error("zeroing with zero floor");
	vrms_zero_a: assert property (ACCUM_TICK && MEAS.vrms[0][31:16] < s_r.startup[31:16] // [RULE_06]
		|=> VRMS_OUT[0] == 32'h0) else $error("low voltage not zeroed");
	gate_low_a: assert property (s_r.stream[`MCR_STR_GATE] && s_r.sh == SH_IDLE // [RULE_20]
		&& $stable(s_r.sh) && $stable(s_r.stream[`MCR_STR_GATE]) |-> !STREAM_CLK)
		else $error("gated clock runs while idle");
	frame_idle_a: assert property (fall_en && s_nxt.sh == SH_IDLE |=> // [RULE_18]
		FRAME_MARKER == $past(s_r.stream[`MCR_STR_FPOL]))
		else $error("frame marker not at rest level");
	stream_word_a: assert property ($rose(s_r.sh == SH_SHIFT) |-> // [RULE_16]
		(s_r.sh == SH_SHIFT) [*8]) else $error("word cut short");
endmodule : mcr_regs

/* File: verification/mcr_stream_sink.sv */
`timescale 1ns/10ps
module mcr_stream_sink (
	input wire logic CLK,
	input wire logic [7:0] RAM_ADDR,
	output logic [31:0] RAM_DATA,
	input wire logic STREAM_CLK,
	input wire logic STREAM_DATA,
	input wire logic FRAME_MARKER,
	input wire logic TEST_MUX_SELECT_OUT,
	input wire logic POL
);
	logic [31:0] sh_d = '0;
	logic [31:0] sh_m = '0;
	int nb = 0;
	int nf = 0;
	realtime t_last = 0.0;
	realtime per = 0.0;
	logic [31:0] words[$];
	logic [31:0] mons[$];
	int frames[$];
	// ------------------------------------------------------------
	// data ram
	// ------------------------------------------------------------
	// pattern differs per address so a wrong start or order shows up
	always @(posedge CLK) begin
		RAM_DATA <= {RAM_ADDR, ~RAM_ADDR, RAM_ADDR ^ 8'h5A, 8'hC3};
	end
	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	// every rising edge is taken as a bit, so a clock running while idle misaligns words
	always @(posedge STREAM_CLK) begin
		if (nb != 0) per = $realtime - t_last;
		t_last = $realtime;
		if (FRAME_MARKER !== POL) nf++;
		sh_m = {sh_m[30:0], TEST_MUX_SELECT_OUT};
		sh_d = {sh_d[30:0], STREAM_DATA};
		nb++;
		if (nb == 32) begin
			words.push_back(sh_d);
			mons.push_back(sh_m);
			frames.push_back(nf);
			nb = 0;
			nf = 0;
		end
	end
endmodule : mcr_stream_sink

/* File: verification/tb_meter_control_register_set.sv */
`timescale 1ns/10ps
`include "mcr_defs.svh"
module tb_meter_control_register_set;
	import mcr_pkg::*;
	localparam int SC = 200;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic mon_en = 1'b0;
	logic [1:0] test_mux_select_sel = 2'h0;
	logic [31:0] load_floor = 32'h0;
	logic accum_tick = 1'b0;
	mcr_meas_t meas = '1;
	logic [7:0] pin_drv = 8'hA0;
	logic pol = 1'b0;
	logic [7:0] ram_addr, pin_out, pin_oe, pin_in;
	logic [31:0] ram_data, reg_rdata, rd;
	logic [2:0][31:0] irms_out, vrms_out;
	logic [2:0] cur_zero, volt_zero, creep, sag_warn;
	logic reg_ack, over_current, over_voltage, pin_edge_event;
	logic stream_clk, stream_data, frame_marker, test_mux_select_out;
	int n_fail = 0;
	int tests_run = 0;
	// input pins see the device where it drives, the bench elsewhere
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);
	always #20 clk = ~clk;
	mcr_regs #(.SAMPLE_CYCLES(SC), .HUNDREDTH_CYCLES(50), .FIFO_DEPTH(16)) i_dut (
		.CLK(clk), .RESET(reset), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack), .MON_EN(mon_en),
		.TEST_MUX_SELECT_SEL(test_mux_select_sel), .LOAD_FLOOR(load_floor), .ACCUM_TICK(accum_tick), .MEAS(meas),
		.RAM_ADDR(ram_addr), .RAM_DATA(ram_data), .IRMS_OUT(irms_out), .VRMS_OUT(vrms_out),
		.CUR_ZERO(cur_zero), .VOLT_ZERO(volt_zero), .CREEP(creep), .SAG_WARN(sag_warn),
		.OVER_CURRENT(over_current), .OVER_VOLTAGE(over_voltage),
		.PIN_EDGE_EVENT(pin_edge_event), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.STREAM_CLK(stream_clk), .STREAM_DATA(stream_data), .FRAME_MARKER(frame_marker),
		.TEST_MUX_SELECT_OUT(test_mux_select_out));
	mcr_stream_sink i_sink (.CLK(clk), .RAM_ADDR(ram_addr), .RAM_DATA(ram_data),
		.STREAM_CLK(stream_clk), .STREAM_DATA(stream_data), .FRAME_MARKER(frame_marker),
		.TEST_MUX_SELECT_OUT(test_mux_select_out), .POL(pol));
	// ------------------------------------------------------------
	// common tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tmo(input int i, input int n);
		if (i >= n) begin
			n_fail++;
			stop_test();
		end
	endtask : tmo
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(negedge clk);
		reg_wr = wr;
		reg_rd = !wr;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		for (i = 0; i < 4 && reg_ack !== 1'b1; i++) @(negedge clk);
		tmo(i, 4);
		rd = reg_rdata;
	endtask : bus
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	task automatic tick();
		@(negedge clk);
		accum_tick = 1'b1;
		@(negedge clk);
		accum_tick = 1'b0;
		@(negedge clk);
	endtask : tick
	function automatic logic [31:0] ramw(input logic [7:0] a);
		return {a, ~a, a ^ 8'h5A, 8'hC3};
	endfunction : ramw
	function automatic int fexp(input logic [1:0] sp, input int i, input int c);
		return (sp == 2'h0) ? int'(i % c == 0) : (8 >> sp);
	endfunction : fexp
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [7:0] a[5] = '{`MCR_OFS_OVERLOAD, `MCR_OFS_TIME, `MCR_OFS_DATE,
			`MCR_OFS_MONSEL, `MCR_OFS_STREAM};
		logic [31:0] d[5] = '{32'hFFFF_FFFF, 32'h3B1E_1707, 32'h1F0C_FF00, 32'h0A0B_0C0D,
			32'h0004_ABCD};
		logic [31:0] e[5] = '{32'hFFFF_FFFF, 32'h3B1E_1707, 32'h1F0C_FF00, 32'h0A0B_0C0D,
			32'h0004_ABCD};
		rdc(`MCR_OFS_SAG, 32'h0000_0050);
		rdc(8'h23, 32'h0);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, a[i], d[i]);
			rdc(a[i], e[i]);
		end
		// gated clock from here on, so the sink sees no stray edges while idle
		bus(1'b1, `MCR_OFS_STREAM, 32'h0020_0000);
	endtask : t_regs
	task automatic t_run();
		bus(1'b1, `MCR_OFS_DATE, 32'h0101_1800);
		rdc(`MCR_OFS_RUNTIME, 32'h0);
		repeat (250) @(negedge clk);
		bus(1'b1, `MCR_OFS_RUNTIME, 32'hFFFF_FFFF);
		rdc(`MCR_OFS_RUNTIME, 32'h5);
		bus(1'b1, `MCR_OFS_TIME, 32'h0000_0001);
		rdc(`MCR_OFS_RUNTIME, 32'h0);
	endtask : t_run
	task automatic t_pins();
		bus(1'b1, `MCR_OFS_PINCTL, 32'h800F_5505);
		repeat (4) @(negedge clk);
		chk(pin_oe, 8'h0F);
		chk(pin_out, 8'h05);
		rdc(`MCR_OFS_PINCTL, 32'h800F_00A5);
		bus(1'b1, `MCR_OFS_PINCTL, 32'h800F_00FF);
		chk(pin_out, 8'h0F);
		tick();
		chk(pin_edge_event, 1'b0);
		pin_drv[7] = 1'b0;
		repeat (4) @(negedge clk);
		tick();
		chk(pin_edge_event, 1'b1);
		pin_drv[6] = 1'b1;
		repeat (4) @(negedge clk);
		tick();
		chk(pin_edge_event, 1'b0);
	endtask : t_pins
	task automatic t_start();
		bus(1'b1, `MCR_OFS_STARTUP, 32'h0100_0010);
		load_floor = 32'h1;
		meas.cur_sqsum = {32'h20, 32'h10, 32'h0F};
		meas.irms = {3{32'h1234_5678}};
		meas.vrms = {32'h0200_0000, 32'h00FF_FFFF, 32'h0100_0000};
		tick();
		chk(creep, 3'b001);
		chk(cur_zero, 3'b001);
		chk(volt_zero, 3'b010);
		chk(irms_out[0], 32'h0);
		chk(irms_out[1], 32'h1234_5678);
		chk(vrms_out[1], 32'h0);
		chk(vrms_out[0], 32'h0100_0000);
		load_floor = 32'h0;
		tick();
		chk(cur_zero, 3'b000);
		chk(creep, 3'b001);
		chk(irms_out[0], 32'h1234_5678);
	endtask : t_start
	task automatic t_alarm();
		bus(1'b1, `MCR_OFS_OVERLOAD, 32'h0200_0100);
		meas.irms = {3{32'h0100_FFFF}};
		meas.vrms = {3{32'h0200_FFFF}};
		tick();
		chk({over_voltage, over_current}, 2'b00);
		meas.irms[2] = 32'h0101_0000;
		tick();
		chk({over_voltage, over_current}, 2'b01);
		meas.vrms[1] = 32'h0201_0000;
		tick();
		chk({over_voltage, over_current}, 2'b11);
	endtask : t_alarm
	task automatic t_sag();
		int i;
		bus(1'b1, `MCR_OFS_SAG, 32'h0100_0003);
		meas.peak = {16'h0200, 16'h0200, 16'h00FF};
		for (i = 0; i < 4 * SC && sag_warn[0] !== 1'b1; i++) @(negedge clk);
		tmo(i, 4 * SC);
		chk(i >= 2 * SC, 1'b1);
		chk(sag_warn, 3'b001);
		meas.peak[0] = 16'h0101;
		repeat (2 * SC) @(negedge clk);
		chk(sag_warn, 3'b000);
	endtask : t_sag
	task automatic t_stream(input logic [31:0] cfg);
		int i;
		int c;
		c = cfg[7:0];
		pol = cfg[18];
		i_sink.words.delete();
		i_sink.frames.delete();
		i_sink.nb = 0;
		i_sink.nf = 0;
		bus(1'b1, `MCR_OFS_STREAM, cfg);
		for (i = 0; i < 8 * SC && i_sink.words.size() < 2 * c; i++) @(negedge clk);
		tmo(i, 8 * SC);
		for (i = 0; i < 2 * c; i++) begin
			chk(i_sink.words[i], ramw(cfg[15:8] + 8'(i % c)));
			chk(i_sink.frames[i], fexp(cfg[20:19], i, c));
		end
		chk(i_sink.per == (cfg[22] ? 2 : 5) * 40.0, 1'b1);
		// stop new blocks but keep the gate, then let the fifo drain fully
		bus(1'b1, `MCR_OFS_STREAM, cfg & 32'hFF7F_FFFF);
		repeat (8 * SC) @(negedge clk);
	endtask : t_stream
	task automatic t_mon();
		int i;
		bus(1'b1, `MCR_OFS_MONSEL, 32'h4142_4344);
		mon_en = 1'b1;
		test_mux_select_sel = 2'h3;
		pol = 1'b0;
		i_sink.mons.delete();
		i_sink.nb = 0;
		bus(1'b1, `MCR_OFS_STREAM, 32'h00A0_0000);
		for (i = 0; i < 8 * SC && i_sink.mons.size() < 4; i++) @(negedge clk);
		tmo(i, 8 * SC);
		for (i = 0; i < 4; i++) begin
			chk(i_sink.mons[i], ramw(8'h41 + 8'(i)));
		end
	endtask : t_mon
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		t_regs();
		t_run();
		t_pins();
		t_start();
		t_alarm();
		t_sag();
		t_stream(32'h00A0_1002);
		t_stream(32'h00EC_2003);
		t_stream(32'h00F4_4001);
		t_stream(32'h00B8_3001);
		t_mon();
		stop_test();
	end
endmodule : tb_meter_control_register_set
